/* File: design/memory_space_decoder.sv */
// Memory-space decoder: program fetch, code-table, main RAM, SFR, aux RAM, xdata.
// Assumes the core waits on BUSY, owns the Special_function_space and the code ROM array.
//
// Overview of operation
// RL1: Fetch-select pin latched at reset, then ignored
// RL2: Table reads from external code hide ROM
// RL3: Security bit set blocks ROM; clear is unrestricted
// RL4: Main RAM 256 bytes; upper half indirect only
// RL5: Direct upper addresses go to SFR space
// RL6: Aux RAM via external moves, any pointer
// RL7: Aux RAM access leaves bus pins untouched
// RL8: Four eight-byte banks at 0-31, one active
// RL9: Bit n at byte 20h+n/8, bit n%8
// RL10: Stack may sit anywhere in main RAM
// RL11: Data-pointer moves above 255 use external bus
// RL12: Pointer-register moves never reach external memory
// RL13: Low 256 xdata bytes map to aux RAM
// RL14: PSW bank field selects active bank
`timescale 1ns/100ps
`default_nettype none
module memory_space_decoder #(
  parameter logic [3:0] STROBE_CYCLES = memdec_pkg::EXT_STROBE_CYCLES
) (
  // Clock and reset
  input  wire logic                 CLK,
  input  wire logic                 RESET_N,
  // Straps and core status
  input  wire logic                 FETCH_REGION_SELECT,
  input  wire logic                 SECURITY_BIT,
  input  wire logic [1:0]           BANK_SELECT,
  // Core request and answer
  input  wire logic                 REQ_VALID,
  input  wire memdec_pkg::req_t     REQ,
  output logic                      BUSY,
  output logic                      RESP_VALID,
  output logic [7:0]                RESP_RDATA,
  output logic                      FETCH_INTERNAL,
  // Internal code ROM
  output logic                      CODE_RD,
  output logic [15:0]               CODE_ADDR,
  input  wire logic [7:0]           CODE_DATA,
  // Special function space
  output memdec_pkg::sfr_req_t      SFR,
  input  wire logic [7:0]           SFR_RDATA,
  // External memory pins
  output memdec_pkg::pins_t         PINS,
  input  wire logic [7:0]           AD_IN
);

  if (STROBE_CYCLES < 4'h3) $error("STROBE_CYCLES must cover the input synchroniser");
  typedef enum logic [2:0] {S_LOCK, S_IDLE, S_CODE, S_SFR, S_EXT_ADDR, S_EXT_STROBE} state_t;
  typedef struct packed {
    state_t                fsm;
    logic [2:0]            sel_sync;
    logic                  fetch_internal;
    logic                  exec_external;
    memdec_pkg::op_t       op;
    logic [15:0]           addr;
    logic [7:0]            wdata;
    logic [7:0]            ad_s1;
    logic [7:0]            ad_s2;
    logic [7:0]            ad_s3;
    logic [3:0]            count;
    logic                  busy;
    logic                  resp_valid;
    logic [7:0]            resp_rdata;
    logic                  code_rd;
    logic [15:0]           code_addr;
    memdec_pkg::sfr_req_t  sfr;
    memdec_pkg::pins_t     pins;
  } st_t;
  st_t        st;
  st_t        next_st;
  logic [7:0] main_ram [256];
  logic [7:0] aux_ram  [256];
  logic       ram_we;
  logic [7:0] ram_waddr;
  logic [7:0] ram_wdata;
  logic       aux_we;
  logic [7:0] aux_waddr;
  logic [7:0] take_bank_addr;
  logic [7:0] take_pointer;
  logic [7:0] take_bit_byte;
  logic [7:0] bit_byte_value;
  logic       take;
  assign take           = REQ_VALID && !st.busy && st.fsm == S_IDLE;
  assign take_bank_addr = {3'h0, BANK_SELECT, REQ.addr[2:0]};                    // [RL8] [RL14]
  assign take_pointer   = main_ram[{3'h0, BANK_SELECT, 2'h0, REQ.ptr_sel}];      // [RL4] [RL6]
  assign take_bit_byte  = 8'(memdec_pkg::BIT_AREA_BASE + {4'h0, REQ.addr[6:3]}); // [RL9]
  assign bit_byte_value = main_ram[take_bit_byte];
  always_comb begin
    logic [7:0] merged;
    merged    = 8'h00;
    next_st   = st;
    ram_we    = 1'b0;
    ram_waddr = 8'h00;
    ram_wdata = 8'h00;
    aux_we    = 1'b0;
    aux_waddr = 8'h00;
    next_st.ad_s1      = AD_IN;
    next_st.ad_s2      = st.ad_s1;
    next_st.ad_s3      = st.ad_s2;
    next_st.sel_sync   = {st.sel_sync[1:0], FETCH_REGION_SELECT};
    next_st.resp_valid = 1'b0;
    next_st.code_rd    = 1'b0;
    next_st.sfr.rd     = 1'b0;
    next_st.sfr.wr     = 1'b0;
    unique case (st.fsm)
      S_LOCK: begin
        if (st.count != 4'h0) begin
          next_st.count = st.count - 4'h1;
        end else if (st.sel_sync[1] == st.sel_sync[2]) begin
          next_st.fetch_internal = st.sel_sync[2];                               // [RL1]
          next_st.fsm            = S_IDLE;
        end
      end
      S_IDLE: begin
        if (take) begin
          next_st.op    = REQ.op;
          next_st.addr  = REQ.addr;
          next_st.wdata = REQ.wdata;
          unique case (REQ.op)
            memdec_pkg::OP_FETCH, memdec_pkg::OP_CODE_TABLE: begin
              if (st.fetch_internal && REQ.addr <= memdec_pkg::CODE_INTERNAL_TOP) begin
                if (REQ.op == memdec_pkg::OP_CODE_TABLE && st.exec_external
                    && SECURITY_BIT) begin                                       // [RL2] [RL3]
                  next_st.resp_valid = 1'b1;
                  next_st.resp_rdata = memdec_pkg::BLOCKED_CODE_BYTE;
                end else begin
                  next_st.code_rd   = 1'b1;                                      // [RL1]
                  next_st.code_addr = REQ.addr;
                  next_st.fsm       = S_CODE;
                  if (REQ.op == memdec_pkg::OP_FETCH) next_st.exec_external = 1'b0;
                end
              end else begin
                next_st.fsm = S_EXT_ADDR;                                        // [RL1]
                if (REQ.op == memdec_pkg::OP_FETCH) next_st.exec_external = 1'b1;
              end
            end
            memdec_pkg::OP_DIRECT_RD, memdec_pkg::OP_DIRECT_WR: begin
              if (REQ.addr[memdec_pkg::UPPER_HALF_BIT]) begin                    // [RL5]
                next_st.sfr.addr  = REQ.addr[7:0];
                next_st.sfr.wdata = REQ.wdata;
                if (REQ.op == memdec_pkg::OP_DIRECT_WR) begin
                  next_st.sfr.wr     = 1'b1;
                  next_st.resp_valid = 1'b1;
                end else begin
                  next_st.sfr.rd = 1'b1;
                  next_st.fsm    = S_SFR;
                end
              end else begin
                next_st.resp_valid = 1'b1;                                       // [RL4]
                next_st.resp_rdata = main_ram[REQ.addr[7:0]];
                ram_we    = REQ.op == memdec_pkg::OP_DIRECT_WR;
                ram_waddr = REQ.addr[7:0];
                ram_wdata = REQ.wdata;
              end
            end
            memdec_pkg::OP_INDIRECT_RD, memdec_pkg::OP_INDIRECT_WR: begin
              next_st.resp_valid = 1'b1;                                         // [RL4]
              next_st.resp_rdata = main_ram[take_pointer];
              ram_we    = REQ.op == memdec_pkg::OP_INDIRECT_WR;
              ram_waddr = take_pointer;
              ram_wdata = REQ.wdata;
            end
            memdec_pkg::OP_STACK_RD, memdec_pkg::OP_STACK_WR: begin
              next_st.resp_valid = 1'b1;                                         // [RL10]
              next_st.resp_rdata = main_ram[REQ.addr[7:0]];
              ram_we    = REQ.op == memdec_pkg::OP_STACK_WR;
              ram_waddr = REQ.addr[7:0];
              ram_wdata = REQ.wdata;
            end
            memdec_pkg::OP_REG_RD, memdec_pkg::OP_REG_WR: begin
              next_st.resp_valid = 1'b1;                                         // [RL8]
              next_st.resp_rdata = main_ram[take_bank_addr];
              ram_we    = REQ.op == memdec_pkg::OP_REG_WR;
              ram_waddr = take_bank_addr;
              ram_wdata = REQ.wdata;
            end
            memdec_pkg::OP_BIT_RD, memdec_pkg::OP_BIT_WR: begin
              if (REQ.addr[memdec_pkg::UPPER_HALF_BIT]) begin
                next_st.sfr.rd   = 1'b1;                                         // [RL5]
                next_st.sfr.addr = {REQ.addr[7:3], 3'h0};
                next_st.fsm      = S_SFR;
              end else begin
                merged = bit_byte_value;
                merged[REQ.addr[2:0]] = REQ.wdata[0];                            // [RL9]
                next_st.resp_valid = 1'b1;
                next_st.resp_rdata = {7'h00, bit_byte_value[REQ.addr[2:0]]};
                ram_we    = REQ.op == memdec_pkg::OP_BIT_WR;
                ram_waddr = take_bit_byte;
                ram_wdata = merged;
              end
            end
            memdec_pkg::OP_XPTR_RD, memdec_pkg::OP_XPTR_WR: begin
              next_st.resp_valid = 1'b1;                                         // [RL6] [RL12]
              next_st.resp_rdata = aux_ram[take_pointer];
              aux_we    = REQ.op == memdec_pkg::OP_XPTR_WR;
              aux_waddr = take_pointer;
            end
            memdec_pkg::OP_XDPTR_RD, memdec_pkg::OP_XDPTR_WR: begin
              if (REQ.addr <= memdec_pkg::AUX_TOP) begin                         // [RL13] [RL7]
                next_st.resp_valid = 1'b1;
                next_st.resp_rdata = aux_ram[REQ.addr[7:0]];
                aux_we    = REQ.op == memdec_pkg::OP_XDPTR_WR;
                aux_waddr = REQ.addr[7:0];
              end else begin
                next_st.fsm = S_EXT_ADDR;                                        // [RL11]
              end
            end
          endcase
          if (next_st.fsm == S_EXT_ADDR) begin
            next_st.pins.ad_out     = REQ.addr[7:0];
            next_st.pins.ad_oe      = 1'b1;
            next_st.pins.high_addr  = REQ.addr[15:8];
            next_st.pins.addr_latch = 1'b1;
          end
        end
      end
      S_CODE: begin
        next_st.resp_valid = 1'b1;
        next_st.resp_rdata = CODE_DATA;
        next_st.fsm        = S_IDLE;
      end
      S_SFR: begin
        next_st.resp_valid = 1'b1;
        next_st.fsm        = S_IDLE;
        if (st.op == memdec_pkg::OP_DIRECT_RD) begin
          next_st.resp_rdata = SFR_RDATA;
        end else begin
          merged = SFR_RDATA;
          merged[st.addr[2:0]] = st.wdata[0];
          next_st.resp_rdata   = {7'h00, SFR_RDATA[st.addr[2:0]]};
          if (st.op == memdec_pkg::OP_BIT_WR) begin
            next_st.sfr.wr    = 1'b1;
            next_st.sfr.wdata = merged;
          end
        end
      end
      S_EXT_ADDR: begin
        next_st.count           = STROBE_CYCLES;
        next_st.fsm             = S_EXT_STROBE;
        next_st.pins.addr_latch = 1'b0;                                          // [RL11]
        if (st.op == memdec_pkg::OP_XDPTR_WR) begin
          next_st.pins.ad_out         = st.wdata;
          next_st.pins.write_strobe_n = 1'b0;
        end else begin
          next_st.pins.ad_oe = 1'b0;
          if (st.op == memdec_pkg::OP_XDPTR_RD) next_st.pins.read_strobe_n = 1'b0;
          else next_st.pins.program_strobe_n = 1'b0;
        end
      end
      S_EXT_STROBE: begin
        if (st.count != 4'h0) begin
          next_st.count = st.count - 4'h1;
        end else if (st.op == memdec_pkg::OP_XDPTR_WR || st.ad_s2 == st.ad_s3) begin
          next_st.resp_valid            = 1'b1;
          next_st.resp_rdata            = st.ad_s3;
          next_st.pins.ad_oe            = 1'b0;
          next_st.pins.write_strobe_n   = 1'b1;
          next_st.pins.read_strobe_n    = 1'b1;
          next_st.pins.program_strobe_n = 1'b1;
          next_st.fsm                   = S_IDLE;
        end
      end
    endcase
    next_st.busy = next_st.fsm != S_IDLE;
  end
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      st       <= '0;
      st.fsm   <= S_LOCK;
      st.busy  <= 1'b1;
      st.count <= memdec_pkg::LOCK_FILL_CYCLES;
      st.pins  <= '{ad_out: 8'h00, ad_oe: 1'b0, high_addr: memdec_pkg::HIGH_ADDR_RESET,
                    addr_latch: 1'b0, write_strobe_n: 1'b1, read_strobe_n: 1'b1,
                    program_strobe_n: 1'b1};
    end else begin
      st <= next_st;
    end
  end
  always_ff @(posedge CLK) begin
    if (ram_we) main_ram[ram_waddr] <= ram_wdata;
    if (aux_we) aux_ram[aux_waddr] <= REQ.wdata;
  end
  assign BUSY           = st.busy;
  assign RESP_VALID     = st.resp_valid;
  assign RESP_RDATA     = st.resp_rdata;
  assign FETCH_INTERNAL = st.fetch_internal;
  assign CODE_RD        = st.code_rd;
  assign CODE_ADDR      = st.code_addr;
  assign SFR            = st.sfr;
  assign PINS           = st.pins;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  chk_select_held: assert property (st.fsm != S_LOCK && $past(st.fsm) != S_LOCK // [RL1]
    |-> $stable(st.fetch_internal)) else $error("fetch select changed after lock");
  chk_low_fetch_int: assert property (take && REQ.op == memdec_pkg::OP_FETCH // [RL1]
    && st.fetch_internal && REQ.addr <= memdec_pkg::CODE_INTERNAL_TOP
    |=> CODE_RD ##1 RESP_VALID) else $error("internal fetch not served from code ROM");
  chk_high_fetch_ext: assert property (take && REQ.op == memdec_pkg::OP_FETCH // [RL1]
    && (!st.fetch_internal || REQ.addr > memdec_pkg::CODE_INTERNAL_TOP) |=> PINS.addr_latch
    && !CODE_RD ##1 !PINS.program_strobe_n) else $error("fetch not sent to external memory");
  chk_table_blocked: assert property (take && REQ.op == memdec_pkg::OP_CODE_TABLE // [RL2]
    && st.fetch_internal && REQ.addr <= memdec_pkg::CODE_INTERNAL_TOP && st.exec_external
    && SECURITY_BIT |=> RESP_VALID && RESP_RDATA == memdec_pkg::BLOCKED_CODE_BYTE && !CODE_RD)
    else $error("protected code leaked");
  chk_table_free: assert property (take && REQ.op == memdec_pkg::OP_CODE_TABLE // [RL3]
    && st.fetch_internal && REQ.addr <= memdec_pkg::CODE_INTERNAL_TOP && !SECURITY_BIT
    |=> CODE_RD) else $error("unprotected table read refused");
  chk_sfr_direct: assert property (take && REQ.op == memdec_pkg::OP_DIRECT_RD // [RL5]
    && REQ.addr[7] |=> SFR.rd && SFR.addr == $past(REQ.addr[7:0]) ##1 RESP_VALID)
    else $error("upper direct read missed SFR space");
  chk_indirect_ram: assert property (take && REQ.op == memdec_pkg::OP_INDIRECT_RD // [RL4]
    |=> RESP_VALID && !SFR.rd) else $error("indirect read reached SFR space");
  chk_aux_quiet: assert property (take && (REQ.op == memdec_pkg::OP_XPTR_RD // [RL12]
    || REQ.op == memdec_pkg::OP_XPTR_WR) |=> PINS == $past(PINS) && !BUSY)
    else $error("pointer move touched the bus");
  chk_low_xdata: assert property (take && REQ.op == memdec_pkg::OP_XDPTR_RD // [RL7]
    && REQ.addr <= memdec_pkg::AUX_TOP |=> RESP_VALID && PINS == $past(PINS))
    else $error("aux RAM access moved the pins");
  chk_xdata_ext: assert property (take && REQ.op == memdec_pkg::OP_XDPTR_RD // [RL11]
    && REQ.addr > memdec_pkg::AUX_TOP |=> PINS.high_addr == $past(REQ.addr[15:8])
    ##1 !PINS.read_strobe_n) else $error("high xdata read not external");
  chk_bank_write: assert property (take && REQ.op == memdec_pkg::OP_REG_WR // [RL8]
    |-> ram_we && ram_waddr == {3'h0, BANK_SELECT, REQ.addr[2:0]})
    else $error("register write missed active bank");
  chk_bit_byte: assert property (take && REQ.op == memdec_pkg::OP_BIT_WR && !REQ.addr[7] // [RL9]
    |-> ram_we && ram_waddr == memdec_pkg::BIT_AREA_BASE + {4'h0, REQ.addr[6:3]})
    else $error("bit write to wrong byte");
  cov_ext_write: cover property (take && REQ.op == memdec_pkg::OP_XDPTR_WR
    && REQ.addr > memdec_pkg::AUX_TOP);
  cov_blocked_table: cover property (take && REQ.op == memdec_pkg::OP_CODE_TABLE
    && st.exec_external && SECURITY_BIT);
  cov_sfr_bit_write: cover property (take && REQ.op == memdec_pkg::OP_BIT_WR && REQ.addr[7]);

endmodule // memory_space_decoder
`default_nettype wire

/* File: design/memdec_pkg.sv */
// Shared types and constants of the memory-space decoder.
// Assumes one 200 MHz core clock and a core that issues one access at a time.
package memdec_pkg;

  // Clock and external strobe timing
  localparam int          CLK_PERIOD_NS     = 5;
  localparam int          EXT_STROBE_NS     = 25;
  localparam logic [3:0]  EXT_STROBE_CYCLES =
      4'((EXT_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0]  LOCK_FILL_CYCLES  = 4'h3;

  // Address map
  localparam logic [15:0] CODE_INTERNAL_TOP = 16'h3fff;
  localparam logic [15:0] AUX_TOP           = 16'h00ff;
  localparam logic [7:0]  BIT_AREA_BASE     = 8'h20;
  localparam int          UPPER_HALF_BIT    = 7;

  // Blocked table-read byte and reset values
  localparam logic [7:0]  BLOCKED_CODE_BYTE = 8'h00;
  localparam logic [7:0]  HIGH_ADDR_RESET   = 8'h00;

  typedef enum logic [3:0] {
    OP_FETCH, OP_CODE_TABLE, OP_DIRECT_RD, OP_DIRECT_WR, OP_INDIRECT_RD,
    OP_INDIRECT_WR, OP_STACK_RD, OP_STACK_WR, OP_REG_RD, OP_REG_WR,
    OP_BIT_RD, OP_BIT_WR, OP_XPTR_RD, OP_XPTR_WR, OP_XDPTR_RD, OP_XDPTR_WR
  } op_t;

  typedef struct packed {
    op_t         op;
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        ptr_sel;
  } req_t;

  typedef struct packed {
    logic [7:0] ad_out;
    logic       ad_oe;
    logic [7:0] high_addr;
    logic       addr_latch;
    logic       write_strobe_n;
    logic       read_strobe_n;
    logic       program_strobe_n;
  } pins_t;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_req_t;

endpackage

/* File: tb/ext_memory_model.sv */
// External program and data memory on the multiplexed address/data pins.
// Assumes the address is latched while addr_latch is high, one access at a time.
`timescale 1ns/100ps
`default_nettype none
module ext_memory_model (
  // Clock
  input  wire logic              clk,
  // Device pins
  input  wire memdec_pkg::pins_t pins,
  output logic [7:0]             ad_in
);
  logic [7:0]  mem [0:65535];
  logic [15:0] latched = 16'h0000;
  logic [7:0]  last    = 8'h00;
  logic        drive;

  // Preload with an address pattern
  initial begin
    for (int i = 0; i < 65536; i++) begin
      mem[i] = 8'(i) ^ 8'(i >> 8) ^ 8'h3c;
    end
  end

  assign drive = !pins.read_strobe_n || !pins.program_strobe_n;
  // Released bus shows the inverse of the last value, never a stale copy
  assign ad_in = drive ? mem[latched] : ~last;

  always @(posedge clk) begin
    if (pins.addr_latch) begin
      latched <= {pins.high_addr, pins.ad_out};
    end
    if (!pins.write_strobe_n) begin
      mem[latched] <= pins.ad_out;
    end
    if (drive) begin
      last <= mem[latched];
    end
  end
endmodule // ext_memory_model
`default_nettype wire

/* File: tb/memory_space_decoder_test.sv */
// Self-checking bench of the memory-space decoder.
// Assumes the external memory model beside it; code ROM and Special_function_space are patterns here.
`timescale 1ns/100ps
`default_nettype none
`define CHECK(name, exp, got) begin n_compared++; if ((got) !== (exp)) begin err_total++; \
  $display("[FAIL] %s expected %h seen %h", name, exp, got); end end
module memory_space_decoder_test;
  logic                 clk       = 1'b0;
  logic                 reset_n   = 1'b0;
  logic                 strap     = 1'b1;
  logic                 security  = 1'b0;
  logic [1:0]           bank_sel  = 2'h0;
  logic                 req_valid = 1'b0;
  memdec_pkg::req_t     req       = '0;
  logic                 busy;
  logic                 resp_valid;
  logic [7:0]           resp_rdata;
  logic                 fetch_internal;
  logic [15:0]          code_addr;
  logic [7:0]           code_data;
  memdec_pkg::sfr_req_t sfr;
  logic [7:0]           sfr_rdata;
  memdec_pkg::pins_t    pins;
  memdec_pkg::pins_t    snap;
  logic [7:0]           ad_in;
  logic [7:0]           q;
  int                   err_total  = 0;
  int                   n_compared = 0;

  always #2.5 clk = ~clk;

  // Code ROM and SFR space answer with address patterns
  assign code_data = code_addr[7:0] ^ 8'h5a;
  assign sfr_rdata = sfr.addr ^ 8'ha5;

  memory_space_decoder #(.STROBE_CYCLES(4'h3)) dut (
    .CLK(clk), .RESET_N(reset_n), .FETCH_REGION_SELECT(strap), .SECURITY_BIT(security),
    .BANK_SELECT(bank_sel), .REQ_VALID(req_valid), .REQ(req), .BUSY(busy),
    .RESP_VALID(resp_valid), .RESP_RDATA(resp_rdata), .FETCH_INTERNAL(fetch_internal),
    .CODE_RD(), .CODE_ADDR(code_addr), .CODE_DATA(code_data), .SFR(sfr),
    .SFR_RDATA(sfr_rdata), .PINS(pins), .AD_IN(ad_in));

  ext_memory_model ext (.clk(clk), .pins(pins), .ad_in(ad_in));

  function automatic logic [7:0] rom_pat(input logic [15:0] a);
    return a[7:0] ^ 8'h5a;
  endfunction

  function automatic logic [7:0] ext_pat(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h3c;
  endfunction

  task automatic conclude;
    if (err_total == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic do_reset;
    @(posedge clk) reset_n <= 1'b0;
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    for (int n = 0; n < 50 && busy !== 1'b0; n++) @(posedge clk);
  endtask

  // One core access: wait idle, present for one take edge, await the answer
  task automatic acc(input memdec_pkg::op_t op, input logic [15:0] a, input logic [7:0] d,
                     input logic p, output logic [7:0] r);
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 100) begin
      @(posedge clk);
      #1;
      n++;
    end
    @(posedge clk);
    req_valid <= 1'b1;
    req       <= '{op: op, addr: a, wdata: d, ptr_sel: p};
    @(posedge clk);
    req_valid <= 1'b0;
    // One-cycle answers already stand just after the take edge
    #1;
    n = 0;
    while (resp_valid !== 1'b1 && n < 40) begin
      @(posedge clk);
      #1;
      n++;
    end
    `CHECK("resp_valid", 1'b1, resp_valid)
    r = resp_rdata;
  endtask

  task automatic t_strap_high;
    `CHECK("fetch_internal", 1'b1, fetch_internal)
    @(posedge clk) strap <= 1'b0;
    repeat (8) @(posedge clk);
    `CHECK("fetch_internal_held", 1'b1, fetch_internal)
  endtask

  task automatic t_fetch_map;
    acc(memdec_pkg::OP_FETCH, 16'h3fff, 8'h00, 1'b0, q);
    `CHECK("fetch_3fff", rom_pat(16'h3fff), q)
    acc(memdec_pkg::OP_FETCH, 16'h4000, 8'h00, 1'b0, q);
    `CHECK("fetch_4000", ext_pat(16'h4000), q)
  endtask

  task automatic t_security;
    @(posedge clk) security <= 1'b1;
    acc(memdec_pkg::OP_CODE_TABLE, 16'h0020, 8'h00, 1'b0, q);
    `CHECK("table_blocked", memdec_pkg::BLOCKED_CODE_BYTE, q)
    @(posedge clk) security <= 1'b0;
    acc(memdec_pkg::OP_CODE_TABLE, 16'h0020, 8'h00, 1'b0, q);
    `CHECK("table_open", rom_pat(16'h0020), q)
    acc(memdec_pkg::OP_FETCH, 16'h0030, 8'h00, 1'b0, q);
    @(posedge clk) security <= 1'b1;
    acc(memdec_pkg::OP_CODE_TABLE, 16'h0020, 8'h00, 1'b0, q);
    `CHECK("table_from_internal", rom_pat(16'h0020), q)
  endtask

  task automatic t_main_sfr;
    acc(memdec_pkg::OP_REG_WR, 16'h0000, 8'h90, 1'b0, q);
    acc(memdec_pkg::OP_INDIRECT_WR, 16'h0000, 8'h77, 1'b0, q);
    acc(memdec_pkg::OP_INDIRECT_RD, 16'h0000, 8'h00, 1'b0, q);
    `CHECK("indirect_upper", 8'h77, q)
    acc(memdec_pkg::OP_DIRECT_RD, 16'h0090, 8'h00, 1'b0, q);
    `CHECK("direct_sfr", 8'h90 ^ 8'ha5, q)
    acc(memdec_pkg::OP_DIRECT_WR, 16'h0088, 8'h5e, 1'b0, q);
    `CHECK("sfr_wdata", 8'h5e, sfr.wdata)
    `CHECK("sfr_waddr", 8'h88, sfr.addr)
    acc(memdec_pkg::OP_BIT_RD, 16'h0092, 8'h00, 1'b0, q);
    `CHECK("sfr_bit", 8'h01, q)
    acc(memdec_pkg::OP_BIT_WR, 16'h0093, 8'h01, 1'b0, q);
    `CHECK("sfr_bit_merge", 8'h3d, sfr.wdata)
    acc(memdec_pkg::OP_DIRECT_WR, 16'h007f, 8'h3e, 1'b0, q);
    acc(memdec_pkg::OP_DIRECT_RD, 16'h007f, 8'h00, 1'b0, q);
    `CHECK("direct_lower", 8'h3e, q)
  endtask

  task automatic t_banks;
    for (int b = 0; b < 4; b++) begin
      @(posedge clk) bank_sel <= 2'(b);
      acc(memdec_pkg::OP_REG_WR, 16'h0007, 8'h40 + 8'(b), 1'b0, q);
    end
    @(posedge clk) bank_sel <= 2'h0;
    for (int b = 0; b < 4; b++) begin
      acc(memdec_pkg::OP_DIRECT_RD, 16'(8 * b + 7), 8'h00, 1'b0, q);
      `CHECK("bank_reg", 8'h40 + 8'(b), q)
    end
  endtask

  task automatic t_bits;
    acc(memdec_pkg::OP_DIRECT_WR, 16'h0021, 8'h00, 1'b0, q);
    acc(memdec_pkg::OP_BIT_WR, 16'h000b, 8'h01, 1'b0, q);
    acc(memdec_pkg::OP_DIRECT_RD, 16'h0021, 8'h00, 1'b0, q);
    `CHECK("bit_0b_byte", 8'h08, q)
    acc(memdec_pkg::OP_BIT_RD, 16'h000b, 8'h00, 1'b0, q);
    `CHECK("bit_0b", 8'h01, q)
    acc(memdec_pkg::OP_DIRECT_WR, 16'h002f, 8'h00, 1'b0, q);
    acc(memdec_pkg::OP_BIT_WR, 16'h007f, 8'h01, 1'b0, q);
    acc(memdec_pkg::OP_DIRECT_RD, 16'h002f, 8'h00, 1'b0, q);
    `CHECK("bit_7f_byte", 8'h80, q)
  endtask

  task automatic t_stack;
    acc(memdec_pkg::OP_STACK_WR, 16'h00fe, 8'h99, 1'b0, q);
    acc(memdec_pkg::OP_STACK_RD, 16'h00fe, 8'h00, 1'b0, q);
    `CHECK("stack_top", 8'h99, q)
  endtask

  task automatic t_aux_xdata;
    acc(memdec_pkg::OP_REG_WR, 16'h0001, 8'h80, 1'b0, q);
    snap = pins;
    acc(memdec_pkg::OP_XPTR_WR, 16'h0000, 8'h5c, 1'b1, q);
    acc(memdec_pkg::OP_XDPTR_RD, 16'h0080, 8'h00, 1'b0, q);
    `CHECK("aux_by_data_pointer", 8'h5c, q)
    acc(memdec_pkg::OP_XPTR_RD, 16'h0000, 8'h00, 1'b1, q);
    `CHECK("aux_by_ptr", 8'h5c, q)
    `CHECK("pins_kept", snap, pins)
    acc(memdec_pkg::OP_XDPTR_WR, 16'h1234, 8'he1, 1'b0, q);
    acc(memdec_pkg::OP_XDPTR_RD, 16'h1234, 8'h00, 1'b0, q);
    `CHECK("xdata_1234", 8'he1, q)
    acc(memdec_pkg::OP_XDPTR_RD, 16'h0180, 8'h00, 1'b0, q);
    `CHECK("xdata_0180", ext_pat(16'h0180), q)
    `CHECK("high_addr", 8'h01, pins.high_addr)
    acc(memdec_pkg::OP_XPTR_RD, 16'h0000, 8'h00, 1'b1, q);
    `CHECK("ptr_stays_aux", 8'h5c, q)
  endtask

  task automatic t_strap_low;
    do_reset();
    `CHECK("fetch_internal_low", 1'b0, fetch_internal)
    acc(memdec_pkg::OP_FETCH, 16'h0010, 8'h00, 1'b0, q);
    `CHECK("fetch_all_external", ext_pat(16'h0010), q)
  endtask

  initial begin
    do_reset();
    t_strap_high();
    t_fetch_map();
    t_security();
    t_main_sfr();
    t_banks();
    t_bits();
    t_stack();
    t_aux_xdata();
    t_strap_low();
    conclude();
  end

  // Whole sequence needs under two hundred cycles
  initial begin
    #200000;
    err_total++;
    conclude();
  end
endmodule // memory_space_decoder_test
`default_nettype wire
